// >>> irq_ctrl_pkg.sv
// Constants for the two-level interrupt controller
package irq_ctrl_pkg;
  localparam int NUM_SRC = 18;
  localparam int SRC_W   = 5;
  localparam int VEC_W   = 16;
  localparam int LVL_LOW  = 0;
  localparam int LVL_HIGH = 1;
  localparam logic [7:0] ENABLE_RESET   = 8'h00;
  localparam logic [7:0] PRIORITY_RESET = 8'h00;
  localparam int GLOBAL_EN_BIT = 7;
  // Fixed vector base and stride, one constant address per source
  localparam logic [VEC_W-1:0] VEC_BASE   = 16'h0003;
  localparam logic [VEC_W-1:0] VEC_STRIDE = 16'h0008;
  // Detect cycle before the call is signalled
  localparam int DETECT_CYCLES = 1;
  localparam int CALL_CYCLES   = 4;
  localparam int MIN_RESPONSE  = DETECT_CYCLES + CALL_CYCLES;
  localparam int DEPTH_W       = 2;
endpackage

// >>> irq_vector_rom.sv
// Registered table of fixed service addresses, one per source
`timescale 1ns/100ps
module irq_vector_rom
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Lookup
  input  wire logic [SRC_W-1:0]     src,
  output logic      [VEC_W-1:0]     vec
);
  logic [VEC_W-1:0] table_mem [NUM_SRC];

  for (genvar i = 0; i < NUM_SRC; i++) begin : g_tab
    assign table_mem[i] = VEC_BASE + VEC_W'(i) * VEC_STRIDE;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vec <= '0;
    end else if (src < SRC_W'(NUM_SRC)) begin
      vec <= table_mem[src];
    end else begin
      vec <= '0;
    end
  end
endmodule

// >>> irq_ctrl.sv
// Two-level interrupt controller with fixed in-level order
//
// Notes on behaviour
// - Eighteen sources, two priority levels.
// - Source events set pending flag regardless enable.
// - Enabled pending flag raises request after instruction.
// - Return resumes interrupted instruction stream.
// - Disabled pending flags produce no request.
// - Per-source enable bit in three registers.
// - Global enable gates all individual enables.
// - Clear race: multi-cycle next instruction blocks.
// - Cleared enable reads zero inside routine.
// - Some flags cleared by hardware on vector.
// - Flag still set after return re-requests.
// - Software write of one acts as event.
// - High preempts low; high never preempted.
// - Per-source priority bit, resets to low.
// - Higher level served first when simultaneous.
// - Same level decided by fixed source order.
// - Sampled and decoded every clock cycle.
// - One instruction completes after return before call.
// - Equal or lower level waits for return plus one.
`timescale 1ns/100ps
module irq_ctrl
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RST,
  // Source events and software pending writes
  input  wire logic [irq_ctrl_pkg::NUM_SRC-1:0] SRC_EVENT,
  input  wire logic [irq_ctrl_pkg::NUM_SRC-1:0] PEND_SET,
  input  wire logic [irq_ctrl_pkg::NUM_SRC-1:0] PEND_CLR,
  input  wire logic [irq_ctrl_pkg::NUM_SRC-1:0] HW_CLEAR_MASK,
  // Enable and priority writes
  input  wire logic                          EN_WE,
  input  wire logic [7:0]                    INTERRUPT_ENABLE_WDATA,
  input  wire logic                          EXT_EN1_WE,
  input  wire logic [7:0]                    EXT_EN1_WDATA,
  input  wire logic                          EXT_EN2_WE,
  input  wire logic [7:0]                    EXT_EN2_WDATA,
  input  wire logic                          PRI_WE,
  input  wire logic [7:0]                    PRI0_WDATA,
  input  wire logic                          EXT_PRI1_WE,
  input  wire logic [7:0]                    EXT_PRI1_WDATA,
  input  wire logic                          EXT_PRI2_WE,
  input  wire logic [7:0]                    EXT_PRI2_WDATA,
  // CPU sequencer handshake
  input  wire logic                          INSTR_DONE,
  input  wire logic                          INSTR_MULTI,
  input  wire logic                          RETURN_FROM_INTERRUPT_INSTR_DONE,
  input  wire logic                          IRQ_ACK,
  output logic                               IRQ_REQ,
  output logic [irq_ctrl_pkg::VEC_W-1:0]     IRQ_VECTOR,
  output logic [irq_ctrl_pkg::SRC_W-1:0]     IRQ_SRC,
  // Status
  output logic [irq_ctrl_pkg::NUM_SRC-1:0]   PENDING,
  output logic [7:0]                         INTERRUPT_ENABLE_RDATA,
  output logic [7:0]                         EXT_EN1_RDATA,
  output logic [7:0]                         EXT_EN2_RDATA,
  output logic [7:0]                         PRI0_RDATA,
  output logic [7:0]                         EXT_PRI1_RDATA,
  output logic [7:0]                         EXT_PRI2_RDATA,
  output logic                               IN_SERVICE_LOW,
  output logic                               IN_SERVICE_HIGH
);
  import irq_ctrl_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_CALL, ST_HOLD} seq_e;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]         interrupt_enable_reg;
  logic [7:0]         ext_enable_reg_1;
  logic [7:0]         ext_enable_reg_2;
  logic [7:0]         pri0_reg;
  logic [7:0]         ext_priority_reg_1;
  logic [7:0]         ext_priority_reg_2;
  logic [NUM_SRC-1:0] pend_reg;
  logic [NUM_SRC-1:0] pend_next;
  logic               act_low_reg;
  logic               act_high_reg;
  logic               hold_reg;
  logic               block_reg;
  logic               req_reg;
  logic [SRC_W-1:0]   src_reg;
  seq_e               st_reg;
  seq_e               st_next;

  ////////////////////////////////////////////////////////////////////////
  // Lowest index wins within a level
  function automatic logic [SRC_W-1:0] first_set(
    input logic [NUM_SRC-1:0] v);
    logic [SRC_W-1:0] r;
    r = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = SRC_W'(i);
      end
    end
    return r;
  endfunction

  wire logic [23:0]        en_all = {ext_enable_reg_2, ext_enable_reg_1,
                                     1'b0, interrupt_enable_reg[6:0]};
  wire logic [23:0]        pri_all = {ext_priority_reg_2, ext_priority_reg_1,
                                      1'b0, pri0_reg[6:0]};
  wire logic [NUM_SRC-1:0] en_vec = {en_all[18:8], en_all[6:0]};
  wire logic [NUM_SRC-1:0] pri_vec = {pri_all[18:8], pri_all[6:0]};
  wire logic               global_en = interrupt_enable_reg[GLOBAL_EN_BIT];
  wire logic [NUM_SRC-1:0] live =
    pend_reg & en_vec & {NUM_SRC{global_en}};
  wire logic [NUM_SRC-1:0] live_high = live & pri_vec;
  wire logic [NUM_SRC-1:0] live_low  = live & ~pri_vec;
  wire logic               any_high = |live_high;
  wire logic               any_low  = |live_low;
  // High may enter unless high already active; low only when idle
  wire logic               ok_high = any_high & ~act_high_reg;
  wire logic               ok_low  = any_low & ~act_high_reg
                                     & ~act_low_reg;
  wire logic [SRC_W-1:0]   win_src = ok_high ? first_set(live_high)
                                             : first_set(live_low);
  // Race: a multi-cycle instruction after an enable clear blocks entry
  wire logic               fire = (ok_high | ok_low) & INSTR_DONE
                                  & ~hold_reg & ~block_reg;
  wire logic [VEC_W-1:0]   rom_vec;
  wire logic               en_clear =
    (EN_WE & |(interrupt_enable_reg & ~INTERRUPT_ENABLE_WDATA))
    | (EXT_EN1_WE & |(ext_enable_reg_1 & ~EXT_EN1_WDATA))
    | (EXT_EN2_WE & |(ext_enable_reg_2 & ~EXT_EN2_WDATA));

  irq_vector_rom u_rom (
    .clk (CLK),
    .rst (RST),
    .src (win_src),
    .vec (rom_vec)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencing between request and acknowledge
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_RUN:  if (fire) st_next = ST_CALL;
      ST_CALL: if (IRQ_ACK) st_next = ST_RUN;
      ST_HOLD: st_next = ST_RUN;
      default: st_next = ST_RUN;
    endcase
  end

  // Set wins over clear; hardware clears selected flags on vector
  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_pend
      wire logic hw_clr = (st_reg == ST_CALL) & IRQ_ACK
                          & (src_reg == SRC_W'(i)) & HW_CLEAR_MASK[i];
      assign pend_next[i] = SRC_EVENT[i] | PEND_SET[i]
        | (pend_reg[i] & ~PEND_CLR[i] & ~hw_clr);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK) begin
    if (RST) begin
      pend_reg <= '0;
      st_reg   <= ST_RUN;
    end else begin
      pend_reg <= pend_next;
      st_reg   <= st_next;
    end
  end

  // Enable and priority registers; reads return the stored bit
  always_ff @(posedge CLK) begin
    if (RST) begin
      interrupt_enable_reg <= ENABLE_RESET;
      ext_enable_reg_1     <= ENABLE_RESET;
      ext_enable_reg_2     <= ENABLE_RESET;
      pri0_reg             <= PRIORITY_RESET;
      ext_priority_reg_1   <= PRIORITY_RESET;
      ext_priority_reg_2   <= PRIORITY_RESET;
    end else begin
      if (EN_WE) interrupt_enable_reg <= INTERRUPT_ENABLE_WDATA;
      if (EXT_EN1_WE) ext_enable_reg_1 <= EXT_EN1_WDATA;
      if (EXT_EN2_WE) ext_enable_reg_2 <= EXT_EN2_WDATA;
      if (PRI_WE) pri0_reg <= PRI0_WDATA;
      if (EXT_PRI1_WE) ext_priority_reg_1 <= EXT_PRI1_WDATA;
      if (EXT_PRI2_WE) ext_priority_reg_2 <= EXT_PRI2_WDATA;
    end
  end

  // Enable-clear race window closes on a single-cycle follower
  always_ff @(posedge CLK) begin
    if (RST) begin
      block_reg <= 1'b0;
    end else if (en_clear) begin
      block_reg <= 1'b1;
    end else if (INSTR_DONE) begin
      block_reg <= block_reg & INSTR_MULTI;
    end
  end

  // After a return, one more instruction completes first
  always_ff @(posedge CLK) begin
    if (RST) begin
      hold_reg <= 1'b0;
    end else if (RETURN_FROM_INTERRUPT_INSTR_DONE) begin
      hold_reg <= 1'b1;
    end else if (INSTR_DONE) begin
      hold_reg <= 1'b0;
    end
  end

  // Active levels: entry on acknowledge, exit on return
  always_ff @(posedge CLK) begin
    if (RST) begin
      act_low_reg  <= 1'b0;
      act_high_reg <= 1'b0;
    end else if (st_reg == ST_CALL && IRQ_ACK) begin
      if (pri_vec[src_reg]) begin
        act_high_reg <= 1'b1;
      end else begin
        act_low_reg <= 1'b1;
      end
    end else if (RETURN_FROM_INTERRUPT_INSTR_DONE) begin
      if (act_high_reg) begin
        act_high_reg <= 1'b0;
      end else begin
        act_low_reg <= 1'b0;
      end
    end
  end

  // Request and source stand together until acknowledge; vector follows the current winner
  always_ff @(posedge CLK) begin
    if (RST) begin
      req_reg <= 1'b0;
      src_reg <= '0;
    end else if (st_reg == ST_RUN && fire) begin
      req_reg <= 1'b1;
      src_reg <= win_src;
    end else if (st_reg == ST_CALL && IRQ_ACK) begin
      req_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK) begin
    if (RST) begin
      PENDING                <= '0;
      INTERRUPT_ENABLE_RDATA <= '0;
      EXT_EN1_RDATA          <= '0;
      EXT_EN2_RDATA          <= '0;
      PRI0_RDATA             <= '0;
      EXT_PRI1_RDATA         <= '0;
      EXT_PRI2_RDATA         <= '0;
      IN_SERVICE_LOW         <= 1'b0;
      IN_SERVICE_HIGH        <= 1'b0;
    end else begin
      PENDING                <= pend_next;
      INTERRUPT_ENABLE_RDATA <= interrupt_enable_reg;
      EXT_EN1_RDATA          <= ext_enable_reg_1;
      EXT_EN2_RDATA          <= ext_enable_reg_2;
      PRI0_RDATA             <= pri0_reg;
      EXT_PRI1_RDATA         <= ext_priority_reg_1;
      EXT_PRI2_RDATA         <= ext_priority_reg_2;
      IN_SERVICE_LOW         <= act_low_reg;
      IN_SERVICE_HIGH        <= act_high_reg;
    end
  end

  assign IRQ_REQ    = req_reg;
  assign IRQ_SRC    = src_reg;
  assign IRQ_VECTOR = rom_vec;
endmodule

// >>> irq_ctrl_asserts.sv
// Port-level assertions for the interrupt controller
`timescale 1ns/100ps
module irq_ctrl_asserts
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic               CLK,
  input wire logic               RST,
  // Watched inputs
  input wire logic [NUM_SRC-1:0] SRC_EVENT,
  input wire logic [NUM_SRC-1:0] PEND_SET,
  input wire logic [NUM_SRC-1:0] HW_CLEAR_MASK,
  input wire logic               INSTR_DONE,
  input wire logic               RETURN_FROM_INTERRUPT_INSTR_DONE,
  input wire logic               IRQ_ACK,
  // Watched outputs
  input wire logic               IRQ_REQ,
  input wire logic [SRC_W-1:0]   IRQ_SRC,
  input wire logic [NUM_SRC-1:0] PENDING,
  input wire logic [7:0]         INTERRUPT_ENABLE_RDATA,
  input wire logic               IN_SERVICE_LOW,
  input wire logic               IN_SERVICE_HIGH
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  req_hold_a: assert property (
    IRQ_REQ && !IRQ_ACK |=> IRQ_REQ && $stable(IRQ_SRC))
    else $error("request dropped early");
  req_drop_a: assert property (
    IRQ_REQ && IRQ_ACK |=> !IRQ_REQ)
    else $error("request held after ack");
  src_range_a: assert property (
    IRQ_REQ |-> int'(IRQ_SRC) < NUM_SRC)
    else $error("source out of range");
  event_pend_a: assert property (
    !IRQ_ACK |=> (PENDING & ($past(SRC_EVENT) | $past(PEND_SET)))
      == ($past(SRC_EVENT) | $past(PEND_SET)))
    else $error("pending flag not set");
  req_pending_a: assert property (
    $rose(IRQ_REQ) |-> (($past(PENDING) >> IRQ_SRC) & 1) != 0)
    else $error("request without pending flag");
  global_off_a: assert property (
    !INTERRUPT_ENABLE_RDATA[7] && !$past(INTERRUPT_ENABLE_RDATA[7])
      |-> !$rose(IRQ_REQ))
    else $error("request while globally off");
  high_keep_a: assert property (
    IN_SERVICE_HIGH && $past(IN_SERVICE_HIGH) |-> !$rose(IRQ_REQ))
    else $error("high routine preempted");
  return_from_interrupt_instr_wait_a: assert property (
    RETURN_FROM_INTERRUPT_INSTR_DONE && !INSTR_DONE && !IRQ_REQ |=> !IRQ_REQ [*2])
    else $error("request too soon after return");
  ack_clear_a: assert property (
    IRQ_REQ && IRQ_ACK && HW_CLEAR_MASK[IRQ_SRC] && !SRC_EVENT[IRQ_SRC]
      && !PEND_SET[IRQ_SRC] |=> !PENDING[$past(IRQ_SRC)])
    else $error("flag not cleared on vector");
  active_set_a: assert property (
    IRQ_REQ && IRQ_ACK |=> ##1 (IN_SERVICE_LOW || IN_SERVICE_HIGH))
    else $error("no active level after ack");
endmodule

bind irq_ctrl irq_ctrl_asserts chk_u (.*);

// >>> cpu_seq_model.sv
// Behavioural CPU sequencer facing the controller
`timescale 1ns/100ps
module cpu_seq_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Controller side
  input  wire logic irq_req,
  output logic      irq_ack = 1'b0,
  output logic      instr_done = 1'b0,
  output logic      instr_multi = 1'b0,
  output logic      return_from_interrupt_instr_done = 1'b0,
  // Bench control
  input  wire logic return_from_interrupt_instr_go,
  input  wire logic slow
);
  logic [1:0] call_reg = 2'h0;
  logic       phase_reg = 1'b0;
  logic       long_reg = 1'b0;
  always @(posedge clk) begin
    irq_ack <= 1'b0;
    instr_done <= 1'b0;
    instr_multi <= 1'b0;
    return_from_interrupt_instr_done <= 1'b0;
    if (rst) begin
      call_reg <= 2'h0;
    end else if (irq_req && !irq_ack) begin
      // Four cycle call, then ack
      call_reg <= call_reg + 2'h1;
      irq_ack <= (call_reg == 2'h3);
    end else if (return_from_interrupt_instr_go && !return_from_interrupt_instr_done) begin
      return_from_interrupt_instr_done <= 1'b1;
    end else begin
      phase_reg <= ~phase_reg;
      instr_done <= !slow || phase_reg;
      // Slow mode mixes long and short instructions after a clear
      if (!slow || phase_reg) begin
        long_reg <= ~long_reg;
        instr_multi <= slow && long_reg;
      end
    end
  end
endmodule

// >>> tb.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb;
  import irq_ctrl_pkg::*;
  logic CLK = 0, RST = 1, SLOW = 0, RETURN_FROM_INTERRUPT_INSTR_GO = 0, ga;
  logic INSTR_DONE, INSTR_MULTI, RETURN_FROM_INTERRUPT_INSTR_DONE, IRQ_ACK, IRQ_REQ;
  logic IN_SERVICE_LOW, IN_SERVICE_HIGH;
  logic EN_WE = 0, EXT_EN1_WE = 0, EXT_EN2_WE = 0;
  logic PRI_WE = 0, EXT_PRI1_WE = 0, EXT_PRI2_WE = 0;
  logic [17:0] SRC_EVENT = '0, PEND_SET = '0, PEND_CLR = '0;
  logic [17:0] HW_CLEAR_MASK = '0, PENDING, pend, en, pr;
  logic [7:0] INTERRUPT_ENABLE_WDATA = '0, EXT_EN1_WDATA = '0;
  logic [7:0] EXT_EN2_WDATA = '0, PRI0_WDATA = '0;
  logic [7:0] EXT_PRI1_WDATA = '0, EXT_PRI2_WDATA = '0;
  logic [7:0] INTERRUPT_ENABLE_RDATA, EXT_EN1_RDATA, EXT_EN2_RDATA;
  logic [7:0] PRI0_RDATA, EXT_PRI1_RDATA, EXT_PRI2_RDATA;
  logic [15:0] IRQ_VECTOR;
  logic [4:0] IRQ_SRC;
  int fails = 0, cmp_count = 0;

  cpu_seq_model cpu_u (.clk(CLK), .rst(RST), .irq_req(IRQ_REQ),
    .irq_ack(IRQ_ACK), .instr_done(INSTR_DONE), .instr_multi(INSTR_MULTI),
    .return_from_interrupt_instr_done(RETURN_FROM_INTERRUPT_INSTR_DONE), .return_from_interrupt_instr_go(RETURN_FROM_INTERRUPT_INSTR_GO), .slow(SLOW));
  irq_ctrl dut_u (.*);

  initial forever #4 CLK = ~CLK;

  // Reference winner: high level first, then lowest index
  function automatic int winner();
    for (int l = 1; l >= 0; l--)
      for (int s = 0; s < NUM_SRC; s++)
        if (ga && en[s] && pend[s] && pr[s] == l) return s;
    return -1;
  endfunction

  task automatic tick(int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic stop_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic serve();
    int w, k;
    w = winner();
    k = 0;
    while (IRQ_REQ !== 1'b1 && k < 80) begin tick(1); k++; end
    `CHK("src", {1'b1, 5'(w)}, {IRQ_REQ, IRQ_SRC})
    while (IRQ_ACK !== 1'b1 && k < 160) begin tick(1); k++; end
    `CHK("vector", 16'(3 + 8 * w), IRQ_VECTOR)
    tick(1);
    PEND_CLR[w] = 1'b1;
    pend[w] = 1'b0;
    tick(1);
    PEND_CLR = '0;
    RETURN_FROM_INTERRUPT_INSTR_GO = 1'b1;
    tick(1);
    RETURN_FROM_INTERRUPT_INSTR_GO = 1'b0;
  endtask

  initial begin
    repeat (40000) @(posedge CLK);
    fails++;
    stop_test();
  end

  initial begin
    void'($urandom(32'hde74));
    tick(20);
    RST = 0;
    `CHK("pri rst", 24'h0, {EXT_PRI2_RDATA, EXT_PRI1_RDATA, PRI0_RDATA})
    for (int i = 0; i < 30; i++) begin
      ga = ($urandom % 4) != 0;
      en = 18'($urandom);
      pr = 18'($urandom);
      HW_CLEAR_MASK = 18'($urandom);
      INTERRUPT_ENABLE_WDATA = {ga, en[6:0]};
      EXT_EN1_WDATA = en[14:7];
      EXT_EN2_WDATA = {5'h0, en[17:15]};
      PRI0_WDATA = {1'b0, pr[6:0]};
      EXT_PRI1_WDATA = pr[14:7];
      EXT_PRI2_WDATA = {5'h0, pr[17:15]};
      {EN_WE, EXT_EN1_WE, EXT_EN2_WE, PRI_WE, EXT_PRI1_WE, EXT_PRI2_WE} = '1;
      tick(1);
      {EN_WE, EXT_EN1_WE, EXT_EN2_WE, PRI_WE, EXT_PRI1_WE, EXT_PRI2_WE} = '0;
      tick(2);
      `CHK("en", {ga, en}, {INTERRUPT_ENABLE_RDATA[7], EXT_EN2_RDATA[2:0],
        EXT_EN1_RDATA, INTERRUPT_ENABLE_RDATA[6:0]})
      `CHK("pri", pr, {EXT_PRI2_RDATA[2:0], EXT_PRI1_RDATA,
        PRI0_RDATA[6:0]})
      SLOW = 1'($urandom);
      pend = 18'($urandom);
      if (i[0]) SRC_EVENT = pend;
      else PEND_SET = pend;
      tick(1);
      SRC_EVENT = '0;
      PEND_SET = '0;
      `CHK("pending", pend, PENDING)
      while (winner() >= 0) serve();
      tick(4);
      `CHK("idle", {1'b0, pend}, {IRQ_REQ, PENDING})
      PEND_CLR = '1;
      SLOW = 1'b0;
      tick(1);
      PEND_CLR = '0;
    end
    stop_test();
  end
endmodule
